// file: scif_cfg.svh
// register map and field constants for the supply comparator flag block
`ifndef SCIF_CFG_SVH
`define SCIF_CFG_SVH
`define SCIF_ADDR_W      8
`define SCIF_OFF_IEN     8'h0C
`define SCIF_OFF_FLAG    8'h10
`define SCIF_OFF_FSET    8'h14
`define SCIF_OFF_FCLR    8'h18
`define SCIF_BIT_EDGE    0
`define SCIF_BIT_DONE    1
`define SCIF_NFLAG       2
`define SCIF_FLAG_RST    2'h0
`define SCIF_ZERO32      32'h0000_0000
`define SCIF_PAD0        30'h0000_0000
`endif

// file: scif_pkg.sv
// types for the supply comparator flag block
`default_nettype none
package scif_pkg;
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} scif_req_t;
	typedef enum logic [1:0] {
		SCIF_LV_LOW  = 2'b00,
		SCIF_LV_HIGH = 2'b01
	} scif_lvl_t;
endpackage
`default_nettype wire

// file: scif_supply_comparator_flags.sv
// interrupt flag set/clear logic for the supply comparator
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "scif_cfg.svh"
// What this block does
// RQ1 - set-register bit 1 sets done flag
// RQ2 - set-register bit 0 sets edge flag
// RQ3 - clear-register bit 1 clears done flag
// RQ4 - clear-register bit 0 clears edge flag
// RQ5 - software writes zero to bits 31:2
// RQ6 - zero bits no effect; set/clear read zero
// RQ7 - flag register shows done and edge
// RQ8 - irq only for enabled set flags
module scif_supply_comparator_flags
	import scif_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        clkEn,
	// register port
	input  wire logic [7:0]  regAddr,
	input  wire logic [31:0] regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [31:0] regRdata,
	// comparator side
	input  wire logic        cmpOut,
	input  wire logic        warmDone,
	// interrupt
	output logic             irq
);
	scif_req_t req;
	assign req = '{wr: regWr, rd: regRd, addr: regAddr, wdata: regWdata};

	logic [1:0]  flag_q;
	wire logic [1:0] flag_d;
	logic [1:0]  ien_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	// pin chains: two synchroniser stages and one history stage
	logic        cmpS1_q;
	logic        cmpS2_q;
	logic        cmpS3_q;
	logic        wrmS1_q;
	logic        wrmS2_q;
	logic        wrmS3_q;

	// comparator pin chain, either edge counts
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cmpS1_q <= 1'b0;
			cmpS2_q <= 1'b0;
			cmpS3_q <= 1'b0;
		end
		else if (clkEn)
		begin
			cmpS1_q <= cmpOut;
			cmpS2_q <= cmpS1_q;
			cmpS3_q <= cmpS2_q;
		end
	end

	// warm-up pin chain, only the rising edge counts
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			wrmS1_q <= 1'b0;
			wrmS2_q <= 1'b0;
			wrmS3_q <= 1'b0;
		end
		else if (clkEn)
		begin
			wrmS1_q <= warmDone;
			wrmS2_q <= wrmS1_q;
			wrmS3_q <= wrmS2_q;
		end
	end

	wire edgeEv = cmpS2_q ^ cmpS3_q;
	wire doneEv = wrmS2_q & ~wrmS3_q;
	wire [1:0] hwSet = {doneEv, edgeEv};
	wire selIen  = req.addr == `SCIF_OFF_IEN;
	wire selFlag = req.addr == `SCIF_OFF_FLAG;
	wire selSet  = req.addr == `SCIF_OFF_FSET;
	wire selClr  = req.addr == `SCIF_OFF_FCLR;
	wire [1:0] swSet = (req.wr && selSet) ? req.wdata[1:0] : 2'h0;
	wire [1:0] swClr = (req.wr && selClr) ? req.wdata[1:0] : 2'h0;
	// decoded register accesses
	wire       ienWr    = req.wr && selIen;
	wire [1:0] ienWdata = req.wdata[`SCIF_NFLAG-1:0];
	wire       rdIen    = req.rd && selIen;
	wire       rdFlag   = req.rd && selFlag;

	// per-flag update: any set beats a clear
	genvar i;
	generate
		for (i = 0; i < `SCIF_NFLAG; i = i + 1)
		begin : g_flag
			assign flag_d[i] = hwSet[i] | swSet[i] | // RQ1 RQ2 RQ7
				(flag_q[i] & ~swClr[i]); // RQ3 RQ4 RQ6
		end
	endgenerate

	// reads: set, clear and unmapped addresses return zero
	assign rdata_d = rdIen  ? {`SCIF_PAD0, ien_q} :
		rdFlag ? {`SCIF_PAD0, flag_q} : // RQ7
		`SCIF_ZERO32; // RQ6

	// flag register
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			flag_q <= `SCIF_FLAG_RST;
		else if (clkEn)
			flag_q <= flag_d;
	end

	// enable register, only the two low bits are stored
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			ien_q <= `SCIF_FLAG_RST;
		else if (clkEn && ienWr)
			ien_q <= ienWdata; // RQ8
	end

	// read data stands for one clock-enabled cycle only, and holds while clkEn is low
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			rdata_q <= `SCIF_ZERO32;
		else if (clkEn)
			rdata_q <= rdata_d;
	end

	assign regRdata = rdata_q;
	assign irq = |(flag_q & ien_q); // RQ8

	// register write, read and comparator edge checks
	a_set_done: assert property (@(posedge clk) disable iff (sys_rst) // RQ1
		clkEn && regWr && selSet && regWdata[`SCIF_BIT_DONE]
		|=> flag_q[`SCIF_BIT_DONE])
		else $error("done flag not set");
	a_set_edge: assert property (@(posedge clk) disable iff (sys_rst) // RQ2
		clkEn && regWr && selSet && regWdata[`SCIF_BIT_EDGE]
		|=> flag_q[`SCIF_BIT_EDGE])
		else $error("edge flag not set");
	a_clr_done: assert property (@(posedge clk) disable iff (sys_rst) // RQ3
		clkEn && regWr && selClr && regWdata[`SCIF_BIT_DONE] && !doneEv
		|=> !flag_q[`SCIF_BIT_DONE])
		else $error("done flag not cleared");
	a_clr_edge: assert property (@(posedge clk) disable iff (sys_rst) // RQ4
		clkEn && regWr && selClr && regWdata[`SCIF_BIT_EDGE] && !edgeEv
		|=> !flag_q[`SCIF_BIT_EDGE])
		else $error("edge flag not cleared");
	a_zero_keeps: assert property (@(posedge clk) disable iff (sys_rst) // RQ6
		clkEn && regWr && (selSet || selClr) && regWdata[1:0] == 2'h0
		&& hwSet == 2'h0 |=> flag_q == $past(flag_q))
		else $error("zero write changed flags");
	a_setclr_readz: assert property (@(posedge clk) disable iff (sys_rst) // RQ6
		clkEn && regRd && (selSet || selClr) |=> regRdata == `SCIF_ZERO32)
		else $error("set or clear register read nonzero");
	a_flag_read: assert property (@(posedge clk) disable iff (sys_rst) // RQ7
		clkEn && regRd && selFlag |=> regRdata == {30'h0, $past(flag_q)})
		else $error("flag read mismatch");
	a_edge_hw: assert property (@(posedge clk) disable iff (sys_rst) // RQ7
		clkEn && (cmpS2_q != cmpS3_q) |=> flag_q[`SCIF_BIT_EDGE])
		else $error("comparator edge lost");
	a_irq_gate: assert property (@(posedge clk) disable iff (sys_rst) // RQ8
		clkEn && regWr && selClr
		&& (flag_q & ~regWdata[1:0] & ien_q) == 2'h0
		&& (hwSet & ien_q) == 2'h0 |=> !irq)
		else $error("irq stays after clearing enabled flags");
	a_irq_on_set: assert property (@(posedge clk) disable iff (sys_rst) // RQ8
		clkEn && regWr && selSet && (regWdata[1:0] & ien_q) != 2'h0
		|=> irq)
		else $error("irq missing after enabled flag set");

	// enable register and read data
	a_ien_write: assert property (@(posedge clk) disable iff (sys_rst) // RQ8
		clkEn && regWr && selIen |=> ien_q == $past(regWdata[1:0]))
		else $error("enable write lost");
	a_ien_read: assert property (@(posedge clk) disable iff (sys_rst) // RQ8
		clkEn && regRd && selIen
		|=> regRdata == {`SCIF_PAD0, $past(ien_q)})
		else $error("enable read mismatch");
	a_rd_unmapped: assert property (@(posedge clk) disable iff (sys_rst) // RQ6
		clkEn && regRd && !selIen && !selFlag
		|=> regRdata == `SCIF_ZERO32)
		else $error("write-only or unmapped read nonzero");
	a_rdata_idle: assert property (@(posedge clk) disable iff (sys_rst)
		clkEn && !regRd |=> regRdata == `SCIF_ZERO32)
		else $error("read data outlived its cycle");

	// pin events, no spurious flags, clock enable
	a_done_hw: assert property (@(posedge clk) disable iff (sys_rst) // RQ7
		clkEn && wrmS2_q && !wrmS3_q |=> flag_q[`SCIF_BIT_DONE])
		else $error("warm-up done event lost");
	a_done_quiet: assert property (@(posedge clk) disable iff (sys_rst) // RQ7
		clkEn && !flag_q[`SCIF_BIT_DONE] && !doneEv
		&& !swSet[`SCIF_BIT_DONE] |=> !flag_q[`SCIF_BIT_DONE])
		else $error("done flag set without cause");
	a_edge_quiet: assert property (@(posedge clk) disable iff (sys_rst) // RQ7
		clkEn && !flag_q[`SCIF_BIT_EDGE] && !edgeEv
		&& !swSet[`SCIF_BIT_EDGE] |=> !flag_q[`SCIF_BIT_EDGE])
		else $error("edge flag set without cause");
	a_freeze_hold: assert property (@(posedge clk) disable iff (sys_rst)
		!clkEn |=> flag_q == $past(flag_q) && ien_q == $past(ien_q)
		&& regRdata == $past(regRdata))
		else $error("state moved while clock enable low");

	// main scenarios
	c_set_done: cover property (@(posedge clk) disable iff (sys_rst)
		regWr && selSet && regWdata[`SCIF_BIT_DONE] ##1 irq);
	c_clr_flag: cover property (@(posedge clk) disable iff (sys_rst)
		flag_q[0] && regWr && selClr && regWdata[0] ##1 !flag_q[0]);
	c_edge_irq: cover property (@(posedge clk) disable iff (sys_rst)
		edgeEv && ien_q[0] ##1 irq);
	c_set_wins: cover property (@(posedge clk) disable iff (sys_rst)
		edgeEv && regWr && selClr && regWdata[0] ##1 flag_q[0]);
	c_freeze: cover property (@(posedge clk) disable iff (sys_rst)
		!clkEn && regWr);
endmodule
`default_nettype wire

// file: tb.sv
// self-checking bench for the supply comparator flag block
`timescale 1ns/1ps
`default_nettype none
module tb
	import scif_pkg::*;
;
	logic clk, sysRst, clkEn, regWr, regRd, cmpOut, warmDone;
	logic [7:0] regAddr;
	logic [31:0] regWdata, regRdata;
	logic irq;
	int n_fail, compares, cyc;
	scif_supply_comparator_flags dut_u (.clk(clk), .sys_rst(sysRst),
		.clkEn(clkEn), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.cmpOut(cmpOut), .warmDone(warmDone), .irq(irq));
	task results;
		$display("tests done: %0d compares, %0d failures", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e)
		begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		regWr <= 1'b1; regAddr <= a; regWdata <= d;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		regRd <= 1'b1; regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		#1 chk(regRdata, e);
	endtask
	task t_reset;
		rd(8'h10, 32'h0);
		rd(8'h0C, 32'h0);
		chk(irq, 1'b0);
		$display("reset test done");
	endtask
	task t_setclr;
		wr(8'h0C, 32'h3);
		wr(8'h14, 32'h2);
		rd(8'h10, 32'h2);
		chk(irq, 1'b1);
		wr(8'h14, 32'h1);
		rd(8'h10, 32'h3);
		wr(8'h18, 32'h0);
		wr(8'h14, 32'h0);
		rd(8'h10, 32'h3);
		rd(8'h14, 32'h0);
		rd(8'h18, 32'h0);
		wr(8'h18, 32'h2);
		rd(8'h10, 32'h1);
		wr(8'h0C, 32'h2);
		#1 chk(irq, 1'b0);
		wr(8'h18, 32'h1);
		rd(8'h10, 32'h0);
		$display("set clear test done");
	endtask
	task pin(input logic c, input logic w, input logic [31:0] e);
		@(posedge clk);
		cmpOut <= c; warmDone <= w;
		repeat (6) @(posedge clk);
		rd(8'h10, e);
		wr(8'h18, 32'h3);
	endtask
	task t_pins;
		pin(1'b1, 1'b0, 32'h1);
		pin(1'b0, 1'b0, 32'h1);
		pin(1'b0, 1'b1, 32'h2);
		pin(1'b0, 1'b0, 32'h0);
		$display("pin test done");
	endtask
	task t_map;
		rd(8'hFC, 32'h0);
		wr(8'hFC, 32'hFFFF_FFFF);
		rd(8'h0C, 32'h2);
		wr(8'h14, 32'h0);
		rd(8'h10, 32'h0);
		$display("map test done");
	endtask
	task t_race;
		wr(8'h0C, 32'h1);
		@(posedge clk);
		cmpOut <= 1'b1;
		@(posedge clk);
		wr(8'h18, 32'h1);
		rd(8'h10, 32'h1);
		chk(irq, 1'b1);
		wr(8'h18, 32'h1);
		rd(8'h10, 32'h0);
		chk(irq, 1'b0);
		$display("set beats clear test done");
	endtask
	task t_freeze;
		@(posedge clk);
		clkEn <= 1'b0;
		wr(8'h14, 32'h3);
		@(posedge clk);
		clkEn <= 1'b1;
		rd(8'h10, 32'h0);
		rd(8'h0C, 32'h1);
		$display("clock enable test done");
	endtask
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_fail++;
			results();
		end
	end
	initial
	begin
		sysRst = 1'b1; clkEn = 1'b1; regWr = 1'b0; regRd = 1'b0;
		cmpOut = 1'b0; warmDone = 1'b0; regAddr = 8'h0; regWdata = 32'h0;
		repeat (5) @(posedge clk);
		sysRst <= 1'b0;
		t_reset();
		t_setclr();
		t_pins();
		t_map();
		t_race();
		t_freeze();
		results();
	end
endmodule
`default_nettype wire
